// ### rtl/pmbsi_slave.v
`timescale 1ns/1ps
`include "pmbsi_map.vh"

// Summary of operation
// - slave works with bus clocks of 10 to 400 kHz, host stays in range
// - a clock low phase longer than 35 ms abandons the transfer as timeout
// - both lines high over 50 ms resets any transaction in progress
// - timeout and idle reset only act while the disable bit is cleared
// - own clock stretching per message stays within 25 ms in total
// - revision 1.1 command codes are captured and decoded on the bus
// - manufacturer-specific command codes are accepted and flagged as such
// - alert line is driven on request and answered via alert response
// - bus logic handles both 100 kHz and 400 kHz operation
// - device only responds as slave, never starts a transfer itself
module pmbsi_slave #(
   parameter [15:0] TIMEOUT_US = `PMBSI_TIMEOUT_MS * `PMBSI_US_PER_MS,
   parameter [15:0] IDLE_US = `PMBSI_IDLE_MS * `PMBSI_US_PER_MS,
   parameter [15:0] STRETCH_US = `PMBSI_STRETCH_MS * `PMBSI_US_PER_MS
) (
   // clock and reset
   input wire i_clk_sys,
   input wire i_rstn,
   // serial clock line
   input wire i_scl,
   output wire o_scl_o,
   output wire o_scl_oe,
   // serial data line
   input wire i_sda,
   output wire o_sda_o,
   output wire o_sda_oe,
   // alert line
   output wire o_alert_o,
   output wire o_alert_oe,
   // configuration
   input wire [6:0] i_own_addr,
   input wire i_bus_timeout_disable_bit,
   // command and write data toward the device core
   output wire [7:0] o_cmd_code,
   output wire o_cmd_valid,
   output wire o_cmd_mfr,
   output wire [7:0] o_wr_data,
   output wire o_wr_valid,
   // read data from the device core
   output wire o_rd_req,
   input wire [7:0] i_rd_data,
   input wire i_rd_valid,
   // alert request from the device core
   input wire i_alert_req,
   // bus events and status
   output wire o_stop,
   output wire o_timeout,
   output wire o_idle_reset,
   output wire o_stretch_abort,
   output wire o_busy
);

   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_ACK = 3'h2;
   localparam ST_RX = 3'h3;
   localparam ST_TXW = 3'h4;
   localparam ST_TX = 3'h5;
   localparam ST_MACK = 3'h6;
   localparam ST_IGN = 3'h7;

   localparam TICK_CYC = `PMBSI_CLK_KHZ / `PMBSI_KHZ_PER_MHZ;
   localparam TICK_M1 = TICK_CYC - 1;
   localparam [4:0] TICK_LAST = TICK_M1[4:0];
   localparam STRETCH_M1 = STRETCH_US - `PMBSI_STRETCH_GUARD_US;
   localparam [15:0] STRETCH_HIT = STRETCH_M1[15:0];

   function cmd_is_mfr;
      input [7:0] code;
      begin
         cmd_is_mfr = (code >= `PMBSI_MFR_LO) && (code <= `PMBSI_MFR_HI);
      end
   endfunction

   wire scl_s;
   wire sda_s;
   reg scl_p_q;
   reg sda_p_q;
   reg [4:0] div_q;
   reg tick_q;
   reg [15:0] low_us_q;
   reg [15:0] idle_us_q;
   reg [15:0] stretch_us_q;
   reg [2:0] state_q;
   reg [7:0] sh_q;
   reg [3:0] bit_q;
   reg rw_q;
   reg ara_q;
   reg first_q;
   reg mack_q;
   reg scl_oe_q;
   reg sda_oe_q;
   reg rd_req_q;
   reg [7:0] cmd_code_q;
   reg cmd_valid_q;
   reg cmd_mfr_q;
   reg [7:0] wr_data_q;
   reg wr_valid_q;
   reg stop_q;
   reg timeout_q;
   reg idle_rst_q;
   reg abort_q;
   reg ara_done_q;
   reg alert_oe_q;
   reg busy_q;
   reg low_q;

   // lines are oversampled at 20 MHz, 50 cycles per 400 kHz period
   pmbsi_sync #(.RST_VAL(1'b1)) u_scl_sync (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_async(i_scl),
      .o_sync(scl_s)
   );

   pmbsi_sync #(.RST_VAL(1'b1)) u_sda_sync (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_async(i_sda),
      .o_sync(sda_s)
   );

   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   wire scl_rise = scl_s & ~scl_p_q;
   wire scl_fall = ~scl_s & scl_p_q;
   wire bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
   wire bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
   wire guard_en = ~i_bus_timeout_disable_bit;
   wire tmo_hit = guard_en & (low_us_q > TIMEOUT_US) &
      (state_q != ST_IDLE);
   wire idle_hit = guard_en & (idle_us_q > IDLE_US) &
      (state_q != ST_IDLE);
   wire stretch_hit = (stretch_us_q >= STRETCH_HIT);
   wire stretch_clr = bus_stop | tmo_hit | idle_hit |
      (bus_start & (state_q == ST_IDLE));

   // one-microsecond tick for the supervision counters
   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         div_q <= 5'h00;
         tick_q <= 1'b0;
      end else if (div_q == TICK_LAST) begin
         div_q <= 5'h00;
         tick_q <= 1'b1;
      end else begin
         div_q <= div_q + 5'h01;
         tick_q <= 1'b0;
      end
   end

   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         low_us_q <= 16'h0000;
         idle_us_q <= 16'h0000;
         stretch_us_q <= 16'h0000;
      end else begin
         // length of the present clock low phase
         if (scl_s) begin
            low_us_q <= 16'h0000;
         end else if (tick_q && low_us_q != `PMBSI_CNT_MAX) begin
            low_us_q <= low_us_q + 16'h0001;
         end
         // both lines high while a transaction is open
         if (!(scl_s && sda_s) || state_q == ST_IDLE) begin
            idle_us_q <= 16'h0000;
         end else if (tick_q && idle_us_q != `PMBSI_CNT_MAX) begin
            idle_us_q <= idle_us_q + 16'h0001;
         end
         // total own stretching since the initial start
         if (stretch_clr) begin
            stretch_us_q <= 16'h0000;
         end else if (tick_q && scl_oe_q && !stretch_hit) begin
            stretch_us_q <= stretch_us_q + 16'h0001;
         end
      end
   end

   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= ST_IDLE;
         sh_q <= 8'h00;
         bit_q <= 4'h0;
         rw_q <= 1'b0;
         ara_q <= 1'b0;
         first_q <= 1'b0;
         mack_q <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         rd_req_q <= 1'b0;
         cmd_code_q <= 8'h00;
         cmd_valid_q <= 1'b0;
         cmd_mfr_q <= 1'b0;
         wr_data_q <= 8'h00;
         wr_valid_q <= 1'b0;
         stop_q <= 1'b0;
         timeout_q <= 1'b0;
         idle_rst_q <= 1'b0;
         abort_q <= 1'b0;
         ara_done_q <= 1'b0;
      end else begin
         cmd_valid_q <= 1'b0;
         wr_valid_q <= 1'b0;
         stop_q <= 1'b0;
         timeout_q <= 1'b0;
         idle_rst_q <= 1'b0;
         abort_q <= 1'b0;
         if (!i_alert_req) begin
            ara_done_q <= 1'b0;
         end
         if (tmo_hit || idle_hit) begin
            // drop everything and wait for a new start
            state_q <= ST_IDLE;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            rd_req_q <= 1'b0;
            timeout_q <= tmo_hit;
            idle_rst_q <= ~tmo_hit;
         end else if (bus_stop) begin
            stop_q <= (state_q != ST_IDLE);
            state_q <= ST_IDLE;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            rd_req_q <= 1'b0;
         end else if (bus_start) begin
            state_q <= ST_ADDR;
            bit_q <= 4'h0;
            first_q <= 1'b1;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            rd_req_q <= 1'b0;
         end else begin
            case (state_q)
               ST_ADDR: begin
                  if (scl_rise) begin
                     sh_q <= {sh_q[6:0], sda_s};
                     bit_q <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == `PMBSI_BYTE_BITS) begin
                     if (sh_q[7:1] == i_own_addr) begin
                        rw_q <= sh_q[0];
                        ara_q <= 1'b0;
                        sda_oe_q <= 1'b1;
                        state_q <= ST_ACK;
                     end else if (sh_q[7:1] == `PMBSI_ARA_ADDR && sh_q[0] &&
                        alert_oe_q) begin
                        rw_q <= 1'b1;
                        ara_q <= 1'b1;
                        sda_oe_q <= 1'b1;
                        state_q <= ST_ACK;
                     end else begin
                        state_q <= ST_IGN;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     bit_q <= 4'h0;
                     if (!rw_q) begin
                        sda_oe_q <= 1'b0;
                        state_q <= ST_RX;
                     end else if (ara_q) begin
                        sh_q <= {i_own_addr, 1'b0};
                        sda_oe_q <= ~i_own_addr[6];
                        state_q <= ST_TX;
                     end else begin
                        // hold the clock low until read data arrives
                        sda_oe_q <= 1'b0;
                        scl_oe_q <= 1'b1;
                        rd_req_q <= 1'b1;
                        state_q <= ST_TXW;
                     end
                  end
               end
               ST_RX: begin
                  if (scl_rise) begin
                     sh_q <= {sh_q[6:0], sda_s};
                     bit_q <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == `PMBSI_BYTE_BITS) begin
                     if (first_q) begin
                        first_q <= 1'b0;
                        cmd_code_q <= sh_q;
                        cmd_mfr_q <= cmd_is_mfr(sh_q);
                        cmd_valid_q <= 1'b1;
                     end else begin
                        wr_data_q <= sh_q;
                        wr_valid_q <= 1'b1;
                     end
                     sda_oe_q <= 1'b1;
                     state_q <= ST_ACK;
                  end
               end
               ST_TXW: begin
                  if (i_rd_valid) begin
                     sh_q <= i_rd_data;
                     sda_oe_q <= ~i_rd_data[7];
                     rd_req_q <= 1'b0;
                     state_q <= ST_TX;
                  end else if (stretch_hit) begin
                     // budget spent: release and send filler
                     sh_q <= `PMBSI_FILL_BYTE;
                     sda_oe_q <= 1'b0;
                     rd_req_q <= 1'b0;
                     abort_q <= 1'b1;
                     state_q <= ST_TX;
                  end
               end
               ST_TX: begin
                  // data has been set up one cycle before the clock release
                  if (scl_oe_q) begin
                     scl_oe_q <= 1'b0;
                  end else if (scl_rise) begin
                     bit_q <= bit_q + 4'h1;
                  end else if (scl_fall) begin
                     if (bit_q == `PMBSI_BYTE_BITS) begin
                        sda_oe_q <= 1'b0;
                        state_q <= ST_MACK;
                     end else begin
                        sh_q <= {sh_q[6:0], 1'b1};
                        sda_oe_q <= ~sh_q[6];
                     end
                  end
               end
               ST_MACK: begin
                  if (scl_rise) begin
                     mack_q <= ~sda_s;
                     if (ara_q) begin
                        ara_done_q <= 1'b1;
                     end
                  end else if (scl_fall) begin
                     bit_q <= 4'h0;
                     if (!mack_q) begin
                        state_q <= ST_IGN;
                     end else if (ara_q) begin
                        sh_q <= `PMBSI_FILL_BYTE;
                        state_q <= ST_TX;
                     end else begin
                        scl_oe_q <= 1'b1;
                        rd_req_q <= 1'b1;
                        state_q <= ST_TXW;
                     end
                  end
               end
               ST_IDLE: begin
                  state_q <= ST_IDLE;
               end
               ST_IGN: begin
                  state_q <= ST_IGN;
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         alert_oe_q <= 1'b0;
         busy_q <= 1'b0;
         low_q <= 1'b0;
      end else begin
         alert_oe_q <= i_alert_req & ~ara_done_q;
         busy_q <= (state_q != ST_IDLE);
         low_q <= 1'b0;
      end
   end

   // pins are only ever pulled low, and the clock only while stretching
   assign o_scl_o = low_q;
   assign o_scl_oe = scl_oe_q;
   assign o_sda_o = low_q;
   assign o_sda_oe = sda_oe_q;
   assign o_alert_o = low_q;
   assign o_alert_oe = alert_oe_q;
   assign o_cmd_code = cmd_code_q;
   assign o_cmd_valid = cmd_valid_q;
   assign o_cmd_mfr = cmd_mfr_q;
   assign o_wr_data = wr_data_q;
   assign o_wr_valid = wr_valid_q;
   assign o_rd_req = rd_req_q;
   assign o_stop = stop_q;
   assign o_timeout = timeout_q;
   assign o_idle_reset = idle_rst_q;
   assign o_stretch_abort = abort_q;
   assign o_busy = busy_q;

endmodule

// ### rtl/pmbsi_map.vh
`ifndef PMBSI_MAP_VH
`define PMBSI_MAP_VH

// system clock rate and time unit conversions
`define PMBSI_CLK_KHZ 20000
`define PMBSI_KHZ_PER_MHZ 1000
`define PMBSI_US_PER_MS 1000

// serial clock range the slave is built for, in kHz
`define PMBSI_SCL_MIN_KHZ 10
`define PMBSI_SCL_STD_KHZ 100
`define PMBSI_SCL_MAX_KHZ 400

// bus supervision times, in ms
`define PMBSI_TIMEOUT_MS 35
`define PMBSI_IDLE_MS 50
`define PMBSI_STRETCH_MS 25
// release the clock this many us before the stretch budget is spent
`define PMBSI_STRETCH_GUARD_US 1

// bus free time the host keeps between stop and start, in ns
`define PMBSI_BUF_NS 1300

// addresses and command code classes
`define PMBSI_ARA_ADDR 7'h0C
`define PMBSI_MFR_LO 8'hD0
`define PMBSI_MFR_HI 8'hFD

// byte framing
`define PMBSI_BYTE_BITS 4'h8
`define PMBSI_FILL_BYTE 8'hFF
`define PMBSI_CNT_MAX 16'hFFFF

`endif

// ### rtl/pmbsi_sync.v
`timescale 1ns/1ps

module pmbsi_sync #(
   parameter RST_VAL = 1'b1
) (
   // clock and reset
   input wire i_clk_sys,
   input wire i_rstn,
   // pin side
   input wire i_async,
   // filtered level
   output wire o_sync
);

   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg out_q;

   // the output moves only once the second and third stages agree
   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         out_q <= RST_VAL;
      end else begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            out_q <= s3_q;
         end
      end
   end

   assign o_sync = out_q;

endmodule

// ### verification/pmbsi_host.sv
`timescale 1ns/1ps

module pmbsi_host (
   // clock
   input wire i_clk_sys,
   // wire levels
   input wire i_scl,
   input wire i_sda,
   // open-drain pull-downs
   output reg o_scl_oe,
   output reg o_sda_oe
);
   integer q;
   initial begin
      q = 13;
      o_scl_oe = 1'b0;
      o_sda_oe = 1'b0;
   end
   task tick(input integer n);
      repeat (n) @(negedge i_clk_sys);
   endtask
   // let go of the clock, then wait while the target stretches it
   task rel_scl;
      integer k;
      begin
         o_scl_oe = 1'b0;
         k = 0;
         @(negedge i_clk_sys);
         while (!i_scl && k < 20000) begin
            @(negedge i_clk_sys);
            k = k + 1;
         end
      end
   endtask
   task start;
      begin
         o_sda_oe = 1'b0;
         tick(q);
         rel_scl;
         tick(q);
         o_sda_oe = 1'b1;
         tick(q);
         o_scl_oe = 1'b1;
         tick(q);
      end
   endtask
   task stop;
      begin
         o_sda_oe = 1'b1;
         tick(q);
         rel_scl;
         tick(q);
         o_sda_oe = 1'b0;
         tick(30);
      end
   endtask
   task bitx(input b, output r);
      begin
         o_sda_oe = !b;
         tick(q);
         rel_scl;
         tick(q);
         r = i_sda;
         tick(q);
         o_scl_oe = 1'b1;
         tick(q);
      end
   endtask
   task wbyte(input [7:0] b, output ack);
      integer i;
      reg r;
      begin
         for (i = 7; i >= 0; i = i - 1)
            bitx(b[i], r);
         bitx(1'b1, r);
         ack = !r;
      end
   endtask
   task rbyte(input nack, output [7:0] b);
      integer i;
      reg r;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            bitx(1'b1, r);
            b[i] = r;
         end
         bitx(nack, r);
      end
   endtask
endmodule

// ### verification/pmbsi_slave_sva.sv
`timescale 1ns/1ps

module pmbsi_slave_sva #(
   parameter [15:0] TIMEOUT_US = 16'h88B8,
   parameter [15:0] IDLE_US = 16'hC350,
   parameter [15:0] STRETCH_US = 16'h61A8
) (
   // clock and reset
   input wire i_clk_sys,
   input wire i_rstn,
   // bus lines and pull-downs
   input wire i_scl,
   input wire i_sda,
   input wire o_scl_oe,
   input wire o_sda_oe,
   // alert
   input wire o_alert_oe,
   input wire i_alert_req,
   // control and events
   input wire i_bus_timeout_disable_bit,
   input wire [7:0] o_cmd_code,
   input wire o_cmd_valid,
   input wire o_cmd_mfr,
   input wire o_stop,
   input wire o_timeout,
   input wire o_idle_reset,
   input wire o_stretch_abort
);
   localparam int TLIM = TIMEOUT_US * 20;
   localparam int ILIM = IDLE_US * 20;
   localparam int SLIM = STRETCH_US * 20;
   int low_q;
   int high_q;
   int str_q;
   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         low_q <= 0;
         high_q <= 0;
         str_q <= 0;
      end else begin
         low_q <= i_scl ? 0 : low_q + 1;
         high_q <= (i_scl && i_sda) ? high_q + 1 : 0;
         str_q <= (o_stop || o_timeout || o_idle_reset) ? 0 :
            str_q + o_scl_oe;
      end
   end
   default clocking dcb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rstn);
   a_slave_only: assert property (
      ($rose(o_scl_oe) || $rose(o_sda_oe)) |-> !i_scl)
      else $error("pull-down started while clock high");
   a_timeout_time: assert property (o_timeout |->
      !i_bus_timeout_disable_bit && low_q >= TLIM && low_q <= TLIM + 60)
      else $error("timeout at wrong time");
   a_idle_time: assert property (o_idle_reset |->
      !i_bus_timeout_disable_bit && high_q >= ILIM && high_q <= ILIM + 60)
      else $error("idle reset at wrong time");
   a_timeout_free: assert property (
      o_timeout |-> ##[1:2] (!o_scl_oe && !o_sda_oe) [*8])
      else $error("lines held after timeout");
   a_idle_free: assert property (
      o_idle_reset |-> ##[1:2] (!o_scl_oe && !o_sda_oe) [*8])
      else $error("lines held after idle reset");
   a_stretch_cap: assert property (str_q <= SLIM)
      else $error("stretch budget exceeded");
   a_stretch_free: assert property (
      o_stretch_abort |-> ##[0:1] !o_scl_oe [*4])
      else $error("clock held after stretch abort");
   a_cmd_class: assert property (o_cmd_valid |=>
      o_cmd_mfr == (o_cmd_code >= 8'hD0 && o_cmd_code <= 8'hFD))
      else $error("command class wrong");
   a_alert_cause: assert property (o_alert_oe |-> $past(i_alert_req))
      else $error("alert without request");
endmodule

bind pmbsi_slave pmbsi_slave_sva #(
   .TIMEOUT_US(TIMEOUT_US),
   .IDLE_US(IDLE_US),
   .STRETCH_US(STRETCH_US)
) u_sva (
   .i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
   .i_scl(i_scl), .i_sda(i_sda),
   .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe),
   .o_alert_oe(o_alert_oe), .i_alert_req(i_alert_req),
   .i_bus_timeout_disable_bit(i_bus_timeout_disable_bit),
   .o_cmd_code(o_cmd_code), .o_cmd_valid(o_cmd_valid),
   .o_cmd_mfr(o_cmd_mfr), .o_stop(o_stop), .o_timeout(o_timeout),
   .o_idle_reset(o_idle_reset), .o_stretch_abort(o_stretch_abort)
);

// ### verification/tb_top.sv
`timescale 1ns/1ps

module tb_top;
   localparam [6:0] ADDR = 7'h5A;
   // command codes around both edges of the manufacturer range
   localparam [31:0] CODES = 32'hCFD0FDFE;
   reg clk, rstn, dis, alert_req, rd_valid, ack;
   reg [7:0] rd_byte, b, exp;
   integer n_fail, n_tests, rd_lat, rd_cnt, cyc, i;
   integer n_stop, n_to, n_idle, n_sa, n_cmd, n_wr;
   wire scl, sda, h_scl_oe, h_sda_oe, scl_oe, sda_oe;
   wire cmd_mfr, rd_req, alert_oe, busy, stop_p, to_p, idle_p, sa_p;
   wire cmd_vld, wr_vld;
   wire [7:0] cmd_code, wr_data;
   assign scl = !(h_scl_oe || scl_oe);
   assign sda = !(h_sda_oe || sda_oe);
   pmbsi_slave #(.TIMEOUT_US(16'h00C8), .IDLE_US(16'h012C),
      .STRETCH_US(16'h0064)) dut (
      .i_clk_sys(clk), .i_rstn(rstn), .i_scl(scl), .o_scl_o(),
      .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(), .o_sda_oe(sda_oe),
      .o_alert_o(), .o_alert_oe(alert_oe), .i_own_addr(ADDR),
      .i_bus_timeout_disable_bit(dis), .o_cmd_code(cmd_code),
      .o_cmd_valid(cmd_vld), .o_cmd_mfr(cmd_mfr), .o_wr_data(wr_data),
      .o_wr_valid(wr_vld), .o_rd_req(rd_req), .i_rd_data(rd_byte),
      .i_rd_valid(rd_valid), .i_alert_req(alert_req), .o_stop(stop_p),
      .o_timeout(to_p), .o_idle_reset(idle_p), .o_stretch_abort(sa_p),
      .o_busy(busy));
   pmbsi_host host (.i_clk_sys(clk), .i_scl(scl), .i_sda(sda),
      .o_scl_oe(h_scl_oe), .o_sda_oe(h_sda_oe));
   initial forever #25 clk = !clk;
   // event pulses are counted mid-cycle, where they have settled
   always @(negedge clk) begin
      cyc = cyc + 1;
      n_stop = n_stop + stop_p;
      n_cmd = n_cmd + cmd_vld;
      n_wr = n_wr + wr_vld;
      n_to = n_to + to_p;
      n_idle = n_idle + idle_p;
      n_sa = n_sa + sa_p;
      if (cyc == 100000) begin
         n_fail = n_fail + 1;
         final_report;
      end
   end
   // device core answers a read request after rd_lat cycles
   always @(negedge clk) begin
      rd_cnt <= rd_req ? rd_cnt + 1 : 0;
      rd_valid <= rd_req && !rd_valid && rd_cnt >= rd_lat;
      if (rd_valid)
         rd_byte <= rd_byte + 8'h11;
   end
   task check(input [31:0] seen, input [31:0] want);
      begin
         n_tests = n_tests + 1;
         if (seen !== want) begin
            n_fail = n_fail + 1;
            $display("FAIL %0t seen %h expected %h", $time, seen, want);
         end
      end
   endtask
   task final_report;
      begin
         $display("tests %0d mismatches %0d", n_tests, n_fail);
         if (n_fail == 0 && n_tests > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task open(input [7:0] a, input want);
      begin
         host.start;
         host.wbyte(a, ack);
         check(ack, want);
      end
   endtask
   task t_write;
      for (i = 0; i < 4; i = i + 1) begin
         b = CODES[31 - 8 * i -: 8];
         {n_stop, n_cmd, n_wr} = 0;
         open({ADDR, 1'b0}, 1'b1);
         host.wbyte(b, ack);
         check(cmd_code, b);
         check(cmd_mfr, b >= 8'hD0 && b <= 8'hFD);
         host.wbyte(8'h12, ack);
         check(wr_data, 8'h12);
         host.stop;
         check(n_stop, 1);
         check(n_cmd, 1);
         check(n_wr, 1);
      end
   endtask
   task t_refuse;
      for (i = 0; i < 3; i = i + 1) begin
         open((i == 0) ? 8'hB6 : (i == 1) ? 8'h00 : 8'h19, 1'b0);
         host.stop;
      end
   endtask
   task t_read;
      for (i = 0; i < 2; i = i + 1) begin
         host.q = (i == 0) ? 13 : 50;
         if (i == 1) begin
            // command write, then a repeated start into the read
            open({ADDR, 1'b0}, 1'b1);
            host.wbyte(8'h8B, ack);
            check(cmd_code, 8'h8B);
         end
         open({ADDR, 1'b1}, 1'b1);
         host.rbyte(1'b0, b);
         check(b, exp);
         host.rbyte(1'b1, b);
         check(b, exp + 8'h11);
         exp = exp + 8'h22;
         host.stop;
      end
   endtask
   task t_alert;
      begin
         alert_req = 1'b1;
         host.tick(4);
         check(alert_oe, 1);
         open(8'h19, 1'b1);
         host.rbyte(1'b0, b);
         check(b, {ADDR, 1'b0});
         host.rbyte(1'b1, b);
         check(b, 8'hFF);
         host.stop;
         check(alert_oe, 0);
         alert_req = 1'b0;
      end
   endtask
   task t_timeout;
      begin
         for (i = 0; i < 2; i = i + 1) begin
            dis = (i == 1);
            n_to = 0;
            open({ADDR, 1'b0}, 1'b1);
            host.tick(4200);
            check(n_to, i == 0);
            check(busy, i == 1);
            host.stop;
         end
         dis = 1'b0;
         open({ADDR, 1'b0}, 1'b1);
         host.stop;
      end
   endtask
   task t_idle;
      begin
         n_idle = 0;
         open({ADDR, 1'b0}, 1'b1);
         host.rel_scl;
         host.tick(6200);
         check(n_idle, 1);
         check(busy, 0);
      end
   endtask
   task t_stretch;
      begin
         rd_lat = 3000;
         n_sa = 0;
         open({ADDR, 1'b1}, 1'b1);
         host.rbyte(1'b1, b);
         check(b, 8'hFF);
         check(n_sa, 1);
         host.stop;
      end
   endtask
   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      dis = 1'b0;
      alert_req = 1'b0;
      rd_valid = 1'b0;
      rd_byte = 8'hA5;
      exp = 8'hA5;
      {n_fail, n_tests, rd_cnt, cyc, n_stop, n_to, n_idle, n_sa, n_cmd,
         n_wr} = 0;
      rd_lat = 20;
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      repeat (10) @(negedge clk);
      t_write;
      t_refuse;
      t_read;
      host.q = 13;
      t_alert;
      t_timeout;
      t_idle;
      t_stretch;
      final_report;
   end
endmodule
